// ==== hdl/sensor_ctrl_pkg.sv ====
// Shared constants, types and helper functions of the sensor rate and mode control block.
package sensor_ctrl_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] CONTROL_ONE_ADDR = 8'h2a;
  localparam logic [7:0] CONTROL_TWO_ADDR = 8'h2b;
  localparam logic [7:0] CONTROL_ONE_RESET = 8'h08;
  localparam logic [7:0] CONTROL_TWO_RESET = 8'h00;
  // The soft-reset bit and the reserved bit are not stored, so both read as zero.
  localparam logic [7:0] CONTROL_TWO_WMASK = 8'h9f;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  // ==========================================================================
  // Field positions of control_one and control_two
  localparam int ACTIVE_BIT = 0;
  localparam int FAST_READ_BIT = 1;
  localparam int LOW_NOISE_BIT = 2;
  localparam int RATE_SEL_LSB = 3;
  localparam int SLEEP_RATE_LSB = 6;
  localparam int SELFCHECK_EN_BIT = 7;

  // ==========================================================================
  // Output data addresses walked by the burst pointer
  localparam logic [7:0] ACC_X_HIGH = 8'h01;
  localparam logic [7:0] ACC_Y_HIGH = 8'h03;
  localparam logic [7:0] ACC_Z_HIGH = 8'h05;
  localparam logic [7:0] ACC_Z_LOW = 8'h06;
  localparam logic [7:0] MAG_X_HIGH = 8'h33;
  localparam logic [7:0] MAG_Y_HIGH = 8'h35;
  localparam logic [7:0] MAG_Z_HIGH = 8'h37;
  localparam logic [7:0] MAG_Z_LOW = 8'h38;
  localparam logic [7:0] PTR_STEP_ONE = 8'h01;
  localparam logic [7:0] PTR_STEP_TWO = 8'h02;

  // ==========================================================================
  // Full-scale range codes
  localparam logic [1:0] RANGE_2G = 2'b00;
  localparam logic [1:0] RANGE_4G = 2'b01;
  localparam logic [1:0] RANGE_8G = 2'b10;

  // ==========================================================================
  // Timing: every rate is a whole multiple of the 800 Hz base period.
  localparam int CLK_PERIOD_NS = 40;
  localparam int BASE_PERIOD_NS = 1250000;
  localparam int BASE_PERIOD_CYC = BASE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int BASE_CNT_W = 16;
  localparam int MULT_W = 11;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [7:0] control_one;
    logic [7:0] control_two;
    logic [7:0] rdata;
    logic [BASE_CNT_W-1:0] base_cnt;
    logic [MULT_W-1:0] mult_cnt;
    logic [MULT_W-1:0] mult;
    logic tick;
    logic low_noise;
    logic [1:0] range_limit;
    logic [7:0] ptr;
  } state_t;

  // ==========================================================================
  // Functions
  // Wake rate code to period in base periods: 800 Hz down to 1.5625 Hz.
  function automatic logic [MULT_W-1:0] rate_mult(input logic [2:0] code);
    case (code)
      3'h0: rate_mult = 11'h001;
      3'h1: rate_mult = 11'h002;
      3'h2: rate_mult = 11'h004;
      3'h3: rate_mult = 11'h008;
      3'h4: rate_mult = 11'h010;
      3'h5: rate_mult = 11'h040;
      3'h6: rate_mult = 11'h080;
      default: rate_mult = 11'h200;
    endcase
  endfunction

  // Sleep rate code to period in base periods: 50 Hz down to 1.56 Hz.
  function automatic logic [MULT_W-1:0] sleep_mult(input logic [1:0] code);
    case (code)
      2'h0: sleep_mult = 11'h010;
      2'h1: sleep_mult = 11'h040;
      2'h2: sleep_mult = 11'h080;
      default: sleep_mult = 11'h200;
    endcase
  endfunction

  // Next burst address; the fast walk visits high bytes only.
  function automatic logic [7:0] ptr_next(input logic [7:0] p, input logic fast,
                                          input logic link);
    ptr_next = p + PTR_STEP_ONE;
    if (fast) begin
      case (p)
        ACC_X_HIGH, ACC_Y_HIGH, MAG_X_HIGH, MAG_Y_HIGH: ptr_next = p + PTR_STEP_TWO;
        ACC_Z_HIGH: ptr_next = link ? MAG_X_HIGH : ACC_X_HIGH;
        MAG_Z_HIGH: ptr_next = ACC_X_HIGH;
        default: ptr_next = p + PTR_STEP_ONE;
      endcase
    end else begin
      case (p)
        ACC_Z_LOW: ptr_next = link ? MAG_X_HIGH : p + PTR_STEP_ONE;
        MAG_Z_LOW: ptr_next = link ? ACC_X_HIGH : p + PTR_STEP_ONE;
        default: ptr_next = p + PTR_STEP_ONE;
      endcase
    end
  endfunction

endpackage

// ==== hdl/sensor_rate_mode_control.sv ====
// Control registers, sample-rate divider and burst pointer of the sensor block.
`timescale 1ns/1ps

// Notes on behaviour
// - Sleep rate field picks 50, 12.5, 6.25 or 1.56 Hz while asleep.
// - While auto-sleeping, the sleep rate replaces the normal rate everywhere.
// - Hybrid operation halves the sleep sample rate.
// - Three-bit rate field picks 800 Hz down to 1.5625 Hz.
// - Hybrid operation halves the selected output rate.
// - Active bit set means measuring; reset clears it to standby.
// - Low-noise bit doubles gain, allowed only in 2 g or 4 g range.
// - In low-noise mode range tops at 4 g; higher thresholds never cross.
// - Quick-read set gives only the high byte of each axis.
// - Quick-read bursts skip the low-byte addresses of every axis.
// - Hybrid, quick-read and auto-increment: 6-byte burst returns all high bytes.
// - Quick-read bit changes only while FIFO mode field is zero.
// - Hybrid auto-increment without quick-read: 12-byte burst from 0x01 returns all.
module sensor_rate_mode_control #(
  parameter int BASE_CYCLES = sensor_ctrl_pkg::BASE_PERIOD_CYC
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // Register port from the serial bus engine
  input wire sensor_ctrl_pkg::reg_req_t REG_REQ,
  output logic [7:0] REG_RDATA,
  // System context
  input wire logic SLEEP_STATE,
  input wire logic HYBRID_EN,
  input wire logic HYB_AUTOINC,
  input wire logic [1:0] FIFO_MODE,
  input wire logic [1:0] FSR_SEL,
  // Burst address pointer
  input wire logic BURST_LOAD,
  input wire logic [7:0] BURST_ADDR,
  input wire logic BURST_ADV,
  output logic [7:0] BURST_PTR,
  // Mode and rate outputs
  output logic ACTIVE,
  output logic FAST_READ,
  output logic LOW_NOISE,
  output logic [1:0] RANGE_LIMIT,
  output logic SELFCHECK_EN,
  output logic [7:0] CONTROL_TWO,
  output logic [10:0] RATE_PERIOD,
  output logic SAMPLE_TICK
);

  // ==========================================================================
  // State
  sensor_ctrl_pkg::state_t s;
  sensor_ctrl_pkg::state_t next_s;
  logic [sensor_ctrl_pkg::MULT_W-1:0] eff_mult;
  logic link;

  always_comb begin
    next_s = s;
    link = HYBRID_EN & HYB_AUTOINC;
    eff_mult = SLEEP_STATE ?
      sensor_ctrl_pkg::sleep_mult(s.control_one[sensor_ctrl_pkg::SLEEP_RATE_LSB +: 2]) :
      sensor_ctrl_pkg::rate_mult(s.control_one[sensor_ctrl_pkg::RATE_SEL_LSB +: 3]);
    if (HYBRID_EN) begin
      eff_mult = {eff_mult[sensor_ctrl_pkg::MULT_W-2:0], 1'b0};
    end

    // ========================================================================
    // Register writes
    // Standby is not enforced on writes; the host keeps that ordering itself.
    if (REG_REQ.wr && REG_REQ.addr == sensor_ctrl_pkg::CONTROL_ONE_ADDR) begin
      next_s.control_one = REG_REQ.wdata;
      if (FIFO_MODE != 2'b00) begin
        next_s.control_one[sensor_ctrl_pkg::FAST_READ_BIT] =
          s.control_one[sensor_ctrl_pkg::FAST_READ_BIT];
      end
    end
    if (REG_REQ.wr && REG_REQ.addr == sensor_ctrl_pkg::CONTROL_TWO_ADDR) begin
      next_s.control_two = REG_REQ.wdata & sensor_ctrl_pkg::CONTROL_TWO_WMASK;
    end

    // ========================================================================
    // Register reads
    if (REG_REQ.rd) begin
      case (REG_REQ.addr)
        sensor_ctrl_pkg::CONTROL_ONE_ADDR: next_s.rdata = s.control_one;
        sensor_ctrl_pkg::CONTROL_TWO_ADDR: next_s.rdata = s.control_two;
        default: next_s.rdata = sensor_ctrl_pkg::UNMAPPED_DATA;
      endcase
    end

    // ========================================================================
    // Gain mode
    // low-noise only below 8 g
    next_s.low_noise = s.control_one[sensor_ctrl_pkg::LOW_NOISE_BIT] &&
                       FSR_SEL != sensor_ctrl_pkg::RANGE_8G;
    next_s.range_limit = (next_s.low_noise && FSR_SEL != sensor_ctrl_pkg::RANGE_2G) ?
                         sensor_ctrl_pkg::RANGE_4G : FSR_SEL;

    // ========================================================================
    // Sample tick divider
    next_s.tick = 1'b0;
    next_s.mult = eff_mult;
    if (!s.control_one[sensor_ctrl_pkg::ACTIVE_BIT] || eff_mult != s.mult) begin
      next_s.base_cnt = '0;
      next_s.mult_cnt = '0;
    end else if (s.base_cnt == sensor_ctrl_pkg::BASE_CNT_W'(BASE_CYCLES - 1)) begin
      next_s.base_cnt = '0;
      if (s.mult_cnt == s.mult - 11'h001) begin
        next_s.mult_cnt = '0;
        next_s.tick = 1'b1;
      end else begin
        next_s.mult_cnt = s.mult_cnt + 11'h001;
      end
    end else begin
      next_s.base_cnt = s.base_cnt + 16'h0001;
    end

    // ========================================================================
    // Burst pointer
    if (BURST_LOAD) begin
      next_s.ptr = BURST_ADDR;
    end else if (BURST_ADV) begin
      next_s.ptr = sensor_ctrl_pkg::ptr_next(s.ptr,
                     s.control_one[sensor_ctrl_pkg::FAST_READ_BIT], link);
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s <= '{control_one: sensor_ctrl_pkg::CONTROL_ONE_RESET,
             control_two: sensor_ctrl_pkg::CONTROL_TWO_RESET,
             rdata: 8'h00, base_cnt: 16'h0000, mult_cnt: 11'h000,
             mult: 11'h002, tick: 1'b0, low_noise: 1'b0,
             range_limit: 2'b00, ptr: 8'h00};
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // Outputs
  assign REG_RDATA = s.rdata;
  assign BURST_PTR = s.ptr;
  assign ACTIVE = s.control_one[sensor_ctrl_pkg::ACTIVE_BIT];
  assign FAST_READ = s.control_one[sensor_ctrl_pkg::FAST_READ_BIT];
  assign LOW_NOISE = s.low_noise;
  assign RANGE_LIMIT = s.range_limit;
  assign SELFCHECK_EN = s.control_two[sensor_ctrl_pkg::SELFCHECK_EN_BIT];
  assign CONTROL_TWO = s.control_two;
  assign RATE_PERIOD = s.mult;
  assign SAMPLE_TICK = s.tick;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  a_standby_no_tick: assert property (!ACTIVE |=> !SAMPLE_TICK)
    else $error("Sample tick while in standby.");
  a_sleep_rate: assert property (SLEEP_STATE && !HYBRID_EN |=>
    RATE_PERIOD == sensor_ctrl_pkg::sleep_mult($past(s.control_one[7:6])))
    else $error("Sleep period does not follow the sleep rate field.");
  a_sleep_hybrid: assert property (SLEEP_STATE && HYBRID_EN |=>
    RATE_PERIOD == 11'(sensor_ctrl_pkg::sleep_mult($past(s.control_one[7:6])) << 1))
    else $error("Hybrid sleep period is not doubled.");
  a_wake_rate: assert property (!SLEEP_STATE && !HYBRID_EN |=>
    RATE_PERIOD == sensor_ctrl_pkg::rate_mult($past(s.control_one[5:3])))
    else $error("Wake period does not follow the rate field.");
  a_wake_hybrid: assert property (!SLEEP_STATE && HYBRID_EN |=>
    RATE_PERIOD == 11'(sensor_ctrl_pkg::rate_mult($past(s.control_one[5:3])) << 1))
    else $error("Hybrid wake period is not doubled.");
  a_rate_restart: assert property ($changed(RATE_PERIOD) |-> !SAMPLE_TICK)
    else $error("Tick issued in the cycle the rate changed.");
  a_noise_range: assert property (FSR_SEL == sensor_ctrl_pkg::RANGE_8G |=> !LOW_NOISE)
    else $error("Low-noise mode active in the 8 g range.");
  a_noise_cap: assert property (LOW_NOISE |-> RANGE_LIMIT != sensor_ctrl_pkg::RANGE_8G)
    else $error("Low-noise range exceeds 4 g.");
  a_fread_locked: assert property (REG_REQ.wr &&
    REG_REQ.addr == sensor_ctrl_pkg::CONTROL_ONE_ADDR && FIFO_MODE != 2'b00 |=>
    FAST_READ == $past(FAST_READ))
    else $error("Quick-read bit changed while FIFO mode is set.");
  a_fast_skip: assert property (FAST_READ && BURST_ADV && !BURST_LOAD &&
    BURST_PTR == sensor_ctrl_pkg::ACC_X_HIGH |=> BURST_PTR == sensor_ctrl_pkg::ACC_Y_HIGH)
    else $error("Fast burst did not skip the low byte.");
  a_fast_hybrid: assert property (FAST_READ && HYBRID_EN && HYB_AUTOINC && BURST_ADV &&
    !BURST_LOAD && BURST_PTR == sensor_ctrl_pkg::ACC_Z_HIGH |=>
    BURST_PTR == sensor_ctrl_pkg::MAG_X_HIGH)
    else $error("Fast hybrid burst did not move to magnetic data.");
  a_full_hybrid: assert property (!FAST_READ && HYBRID_EN && HYB_AUTOINC && BURST_ADV &&
    !BURST_LOAD && BURST_PTR == sensor_ctrl_pkg::ACC_Z_LOW |=>
    BURST_PTR == sensor_ctrl_pkg::MAG_X_HIGH)
    else $error("Full hybrid burst did not move to magnetic data.");

  c_wake_tick: cover property (ACTIVE && !SLEEP_STATE && SAMPLE_TICK);
  c_sleep_tick: cover property (ACTIVE && SLEEP_STATE && SAMPLE_TICK);
  c_fast_walk: cover property (FAST_READ && BURST_ADV && BURST_PTR == sensor_ctrl_pkg::MAG_Z_HIGH);
  c_fread_refused: cover property (REG_REQ.wr && FIFO_MODE != 2'b00 &&
    REG_REQ.addr == sensor_ctrl_pkg::CONTROL_ONE_ADDR);

endmodule // sensor_rate_mode_control

// ==== test/sensor_host_model.sv ====
// Host processor model that drives the register request port.
`timescale 1ns/1ps
module sensor_host_model (
  // Clock
  input wire logic REF_CLK,
  // Register port
  output sensor_ctrl_pkg::reg_req_t REG_REQ,
  input wire logic [7:0] REG_RDATA
);
  logic [7:0] shadow = 8'h08;

  initial REG_REQ = '0;

  // ==========
  // Bus cycles
  // Idle fields are inverted so that a late sample never sees the old request.
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge REF_CLK);
    REG_REQ <= {1'b1, 1'b0, addr, data};
    @(posedge REF_CLK);
    REG_REQ <= {2'b00, ~addr, ~data};
    if (addr == 8'h2a) shadow = data;
  endtask

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge REF_CLK);
    REG_REQ <= {1'b0, 1'b1, addr, 8'h00};
    @(posedge REF_CLK);
    REG_REQ <= {2'b00, ~addr, 8'hff};
    #1;
    data = REG_RDATA;
  endtask

  task automatic configure(input logic [7:0] value);
    write_reg(8'h2a, shadow & 8'hfe);
    write_reg(8'h2a, value);
  endtask
endmodule // sensor_host_model

// ==== test/sensor_rate_mode_control_bench.sv ====
// Self-checking bench of the sensor rate and mode control block.
`timescale 1ns/1ps
module sensor_rate_mode_control_bench;
  // ==========
  // Signals
  logic REF_CLK, RST_N, SLEEP_STATE, HYBRID_EN, HYB_AUTOINC, BURST_LOAD, BURST_ADV;
  logic ACTIVE, FAST_READ, LOW_NOISE, SELFCHECK_EN, SAMPLE_TICK;
  logic [1:0] FIFO_MODE, FSR_SEL, RANGE_LIMIT;
  logic [7:0] BURST_ADDR, REG_RDATA, BURST_PTR, CONTROL_TWO, rd, v, c1;
  logic [10:0] RATE_PERIOD;
  sensor_ctrl_pkg::reg_req_t REG_REQ;
  int mismatches, tests_run, n;
  logic [31:0] seed = 32'h000035cc;
  logic [10:0] wake_p [8] = '{11'h001, 11'h002, 11'h004, 11'h008, 11'h010, 11'h040,
    11'h080, 11'h200};
  logic [10:0] sleep_p [4] = '{11'h010, 11'h040, 11'h080, 11'h200};
  logic [7:0] walk [15] = '{8'h03, 8'h05, 8'h33, 8'h35, 8'h37, 8'h01, 8'h06, 8'h33,
    8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h01, 8'h01};

  sensor_rate_mode_control #(.BASE_CYCLES(4)) sensor_rate_mode_control_i (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
    .SLEEP_STATE(SLEEP_STATE), .HYBRID_EN(HYBRID_EN), .HYB_AUTOINC(HYB_AUTOINC),
    .FIFO_MODE(FIFO_MODE), .FSR_SEL(FSR_SEL), .BURST_LOAD(BURST_LOAD),
    .BURST_ADDR(BURST_ADDR), .BURST_ADV(BURST_ADV), .BURST_PTR(BURST_PTR),
    .ACTIVE(ACTIVE), .FAST_READ(FAST_READ), .LOW_NOISE(LOW_NOISE),
    .RANGE_LIMIT(RANGE_LIMIT), .SELFCHECK_EN(SELFCHECK_EN), .CONTROL_TWO(CONTROL_TWO),
    .RATE_PERIOD(RATE_PERIOD), .SAMPLE_TICK(SAMPLE_TICK));

  sensor_host_model sensor_host_model_i (
    .REF_CLK(REF_CLK), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA));

  // ==========
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [10:0] exp_period(input logic [7:0] c, input logic s,
                                             input logic h);
    logic [10:0] p;
    p = s ? sleep_p[c[7:6]] : wake_p[c[5:3]];
    return h ? p << 1 : p;
  endfunction

  task automatic check(input logic [10:0] seen, input logic [10:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Counts edges between two ticks; bounded so a silent divider cannot hang us.
  task automatic tick_gap(output int gap);
    gap = 0;
    while (SAMPLE_TICK !== 1'b1 && gap < 5000) begin
      @(posedge REF_CLK);
      #1;
      gap++;
    end
    gap = 0;
    do begin
      @(posedge REF_CLK);
      #1;
      gap++;
    end while (SAMPLE_TICK !== 1'b1 && gap < 5000);
  endtask

  task automatic burst(input logic [7:0] start, input int first, input int count);
    @(posedge REF_CLK);
    BURST_LOAD <= 1'b1;
    BURST_ADDR <= start;
    @(posedge REF_CLK);
    BURST_LOAD <= 1'b0;
    BURST_ADDR <= ~start;
    for (int k = first; k < first + count; k++) begin
      @(posedge REF_CLK);
      BURST_ADV <= 1'b1;
      @(posedge REF_CLK);
      BURST_ADV <= 1'b0;
      #1;
      check(BURST_PTR, walk[k], "burst pointer");
    end
  endtask

  // ==========
  // Clock and watchdog
  initial begin
    REF_CLK = 1'b0;
    forever #20 REF_CLK = ~REF_CLK;
  end

  initial begin
    #800000;
    mismatches++;
    summarize();
  end

  // ==========
  // Scenarios
  initial begin
    RST_N = 1'b0;
    {SLEEP_STATE, HYBRID_EN, HYB_AUTOINC, BURST_LOAD, BURST_ADV} = '0;
    {FIFO_MODE, FSR_SEL, BURST_ADDR} = '0;
    repeat (4) @(posedge REF_CLK);
    RST_N <= 1'b1;
    #1;
    check(ACTIVE, 1'b0, "active after reset");
    check(RATE_PERIOD, 11'h002, "period after reset");
    sensor_host_model_i.read_reg(8'h2a, rd);
    check(rd, 8'h08, "control one reset");
    for (int i = 0; i < 16; i++) begin
      v = rnd();
      c1 = {i[1:0], i[2:0], v[2] & 1'b0, v[1:0] & 2'b01};
      @(posedge REF_CLK);
      SLEEP_STATE <= i[3];
      HYBRID_EN <= v[4];
      sensor_host_model_i.configure(c1);
      repeat (2) @(posedge REF_CLK);
      #1;
      check(RATE_PERIOD, exp_period(c1, SLEEP_STATE, HYBRID_EN), "rate");
      check(ACTIVE, c1[0], "active bit");
    end
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      c1 = {3'b000, v[2:1], 3'b001};
      @(posedge REF_CLK);
      SLEEP_STATE <= 1'b0;
      HYBRID_EN <= v[0];
      sensor_host_model_i.configure(c1);
      tick_gap(n);
      check(11'(n), 11'(4 * exp_period(c1, 1'b0, HYBRID_EN)), "tick gap");
    end
    sensor_host_model_i.configure(8'h00);
    n = 0;
    repeat (40) begin
      @(posedge REF_CLK);
      #1;
      if (SAMPLE_TICK === 1'b1) n++;
    end
    check(11'(n), 11'h000, "tick in standby");
    @(posedge REF_CLK);
    FIFO_MODE <= 2'b01;
    sensor_host_model_i.write_reg(8'h2a, 8'h1a);
    sensor_host_model_i.read_reg(8'h2a, rd);
    check(rd, 8'h18, "locked quick read");
    check(FAST_READ, 1'b0, "fast read held");
    @(posedge REF_CLK);
    FIFO_MODE <= 2'b00;
    sensor_host_model_i.configure(8'h04);
    for (int f = 0; f < 3; f++) begin
      @(posedge REF_CLK);
      FSR_SEL <= f[1:0];
      repeat (2) @(posedge REF_CLK);
      #1;
      check(LOW_NOISE, f != 2, "low noise");
      check(RANGE_LIMIT, f[1:0], "range limit");
    end
    @(posedge REF_CLK);
    HYBRID_EN <= 1'b1;
    HYB_AUTOINC <= 1'b1;
    sensor_host_model_i.configure(8'h02);
    @(posedge REF_CLK);
    #1;
    check(FAST_READ, 1'b1, "fast read");
    burst(8'h01, 0, 6);
    @(posedge REF_CLK);
    HYB_AUTOINC <= 1'b0;
    burst(8'h05, 14, 1);
    @(posedge REF_CLK);
    HYB_AUTOINC <= 1'b1;
    sensor_host_model_i.configure(8'h00);
    burst(8'h05, 6, 8);
    v = rnd();
    sensor_host_model_i.write_reg(8'h2b, v);
    sensor_host_model_i.read_reg(8'h2b, rd);
    check(rd, v & sensor_ctrl_pkg::CONTROL_TWO_WMASK, "control two read");
    check(CONTROL_TWO, v & sensor_ctrl_pkg::CONTROL_TWO_WMASK, "control two out");
    check(SELFCHECK_EN, v[7], "self check");
    sensor_host_model_i.read_reg(8'h2c, rd);
    check(rd, sensor_ctrl_pkg::UNMAPPED_DATA, "unmapped read");
    summarize();
  end
endmodule // sensor_rate_mode_control_bench
